// ---- design/asf_buf.sv ----
`timescale 1ns/1ns
`default_nettype none
module asf_buf
  import asf_pkg::*;
#(
  parameter int WIDTH = WORD_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem [BUF_DEPTH];
  logic wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [1:0] count, next_count;
  logic push, pop;

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = wr_ptr ^ push;
    next_rd_ptr = rd_ptr ^ pop;
    next_count = count + 2'(push) - 2'(pop);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // storage needs no reset: count guards every read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule // asf_buf
`default_nettype wire

// ---- design/asf_frame.sv ----
// Overview of operation
// - one full-duplex frame returns the previous result and carries the next address
// - result goes out in the ten top bits, then six zero bits
// - a frame may be sixteen clocks at once or two bursts of eight
// - half-scale test gives 0x8000, zero test gives 0x0000
// - full-scale test gives 0xffc0
// - end-of-conversion bounds the conversion and may serve as interrupt
// - codes 0 to 4 pick inputs; b, c, d pick test levels
// - address taken on first four rising edges; result shifts on falling edges
// - end-of-conversion falls at tenth falling edge, rises when data ready
`timescale 1ns/1ns
`default_nettype none
module asf_frame
  import asf_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  output logic eoc,
  input wire logic [9:0] analog_input_zero,
  input wire logic [9:0] analog_input_one,
  input wire logic [9:0] analog_input_two,
  input wire logic [9:0] analog_input_three,
  input wire logic [9:0] analog_input_four
);
  ////////////////////////////////////////////////////////////////////////////
  // link side, clocked by the host's serial clock
  logic frame_clr, link_rst;
  logic [3:0] rise_cnt, next_rise_cnt, fall_cnt, next_fall_cnt;
  logic [3:0] link_addr, next_link_addr;
  logic [15:0] tx_word, next_tx_word, stage, next_stage;
  logic start_tog, next_start_tog, ack_tog, next_ack_tog;
  logic tog_s1, tog_s2;
  // core side handshake words
  logic out_tog, next_out_tog;
  logic [15:0] out_word, next_out_word;

  // frame counters restart whenever select is released
  assign frame_clr = cs_n || !rst_n;
  assign link_rst = !rst_n;
  assign dout = tx_word[15];

  always_comb begin
    next_rise_cnt = rise_cnt + 4'h1;
    next_link_addr = link_addr;
    if (rise_cnt < 4'(ADDR_W)) begin
      next_link_addr = {link_addr[2:0], din};
    end
  end

  always_ff @(posedge sclk or posedge frame_clr) begin
    if (frame_clr) begin
      rise_cnt <= 4'h0;
    end else begin
      rise_cnt <= next_rise_cnt;
    end
  end

  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      link_addr <= CODE_IN0;
    end else begin
      link_addr <= next_link_addr;
    end
  end

  always_comb begin
    next_fall_cnt = fall_cnt + 4'h1;
    next_tx_word = tx_word;
    next_stage = stage;
    next_ack_tog = ack_tog;
    if (fall_cnt == FALL_LAST) begin
      next_tx_word = stage;
    end else begin
      next_tx_word = {tx_word[14:0], 1'b0};
    end
    next_start_tog = start_tog ^ (fall_cnt == FALL_START);
    if (tog_s2 != ack_tog) begin
      next_stage = out_word;
      next_ack_tog = tog_s2;
    end
  end

  always_ff @(negedge sclk or posedge frame_clr) begin
    if (frame_clr) begin
      fall_cnt <= 4'h0;
    end else begin
      fall_cnt <= next_fall_cnt;
    end
  end

  // the loaded word and toggles survive select release so no event is lost
  always_ff @(negedge sclk or posedge link_rst) begin
    if (link_rst) begin
      tx_word <= WORD_RESET;
      stage <= WORD_RESET;
      start_tog <= 1'b0;
      ack_tog <= 1'b0;
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
    end else begin
      tx_word <= next_tx_word;
      stage <= next_stage;
      start_tog <= next_start_tog;
      ack_tog <= next_ack_tog;
      tog_s1 <= out_tog;
      tog_s2 <= tog_s1;
    end
  end

  pad_bits_zero_a: assert property (@(negedge sclk) disable iff (frame_clr)
    (fall_cnt >= FALL_PAD) |-> (tx_word[15] == 1'b0))
    else $error("pad bit not zero");

  addr_capture_a: assert property (@(posedge sclk) disable iff (frame_clr)
    (rise_cnt < 4'h4) |=> (link_addr == {$past(link_addr[2:0]), $past(din)}))
    else $error("address bit not captured");

  burst_count_a: assert property (@(posedge sclk) disable iff (frame_clr)
    ##1 (rise_cnt == 4'($past(rise_cnt) + 4'h1)))
    else $error("frame count broke between bursts");

  start_event_a: assert property (@(negedge sclk) disable iff (frame_clr)
    (fall_cnt == FALL_START) |=> (start_tog != $past(start_tog)))
    else $error("no start at tenth fall");

  ////////////////////////////////////////////////////////////////////////////
  // core side: conversion engine
  function automatic logic [9:0] asf_level(input logic [3:0] code,
                                           input logic [49:0] inputs);
    case (code)
      CODE_IN0: asf_level = inputs[9:0];
      CODE_IN1: asf_level = inputs[19:10];
      CODE_IN2: asf_level = inputs[29:20];
      CODE_IN3: asf_level = inputs[39:30];
      CODE_IN4: asf_level = inputs[49:40];
      CODE_HALF: asf_level = LVL_HALF;
      CODE_FULL: asf_level = LVL_FULL;
      // zero test, and the codes that select nothing, read as zero
      default: asf_level = LVL_ZERO;
    endcase
  endfunction

  asf_state_type state, next_state;
  logic [2:0] start_sync;
  logic [1:0] ack_sync;
  logic start_pulse;
  logic [3:0] conv_addr, next_conv_addr, step, next_step;
  logic [9:0] sample, next_sample, result, next_result, trial;
  logic next_eoc;
  logic buf_in_valid, buf_in_ready, buf_out_valid, buf_pop, busy;
  logic [15:0] buf_out_data;

  // stage 0 only feeds stage 1; edges are read between stages 1 and 2
  assign start_pulse = start_sync[1] ^ start_sync[2];
  assign trial = result | (10'h001 << step);
  assign buf_in_valid = (state == ASF_DONE);

  always_comb begin
    next_state = state;
    next_conv_addr = conv_addr;
    next_sample = sample;
    next_result = result;
    next_step = step;
    next_eoc = eoc;
    case (state)
      ASF_IDLE: begin
        if (start_pulse) begin
          // address is stable from the fourth rise until the next frame
          next_conv_addr = link_addr;
          next_sample = asf_level(link_addr, {analog_input_four, analog_input_three,
                                  analog_input_two, analog_input_one, analog_input_zero});
          next_result = LVL_ZERO;
          next_step = STEP_TOP;
          next_eoc = 1'b0;
          next_state = ASF_CONV;
        end
      end
      ASF_CONV: begin
        if (trial <= sample) begin
          next_result = trial;
        end
        if (step == 4'h0) begin
          next_state = ASF_DONE;
        end else begin
          next_step = step - 4'h1;
        end
      end
      ASF_DONE: begin
        if (buf_in_ready) begin
          next_eoc = 1'b1;
          next_state = ASF_IDLE;
        end
      end
      default: next_state = ASF_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= ASF_IDLE;
      conv_addr <= CODE_IN0;
      sample <= LVL_ZERO;
      result <= LVL_ZERO;
      step <= 4'h0;
      eoc <= 1'b1;
      start_sync <= 3'h0;
      ack_sync <= 2'h0;
    end else begin
      state <= next_state;
      conv_addr <= next_conv_addr;
      sample <= next_sample;
      result <= next_result;
      step <= next_step;
      eoc <= next_eoc;
      start_sync <= {start_sync[1:0], start_tog};
      ack_sync <= {ack_sync[0], ack_tog};
    end
  end

  asf_buf #(.WIDTH(WORD_W)) result_buf (
    .clk(core_clk),
    .rst_n(rst_n),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data({result, 6'h00}),
    .out_valid(buf_out_valid),
    .out_ready(buf_pop),
    .out_data(buf_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // word hand-off to the link: toggle out, toggle back once staged
  assign busy = out_tog != ack_sync[1];
  assign buf_pop = buf_out_valid && !busy;

  always_comb begin
    next_out_tog = out_tog ^ buf_pop;
    next_out_word = buf_pop ? buf_out_data : out_word;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      out_tog <= 1'b0;
      out_word <= WORD_RESET;
    end else begin
      out_tog <= next_out_tog;
      out_word <= next_out_word;
    end
  end

  eoc_fall_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == ASF_IDLE && start_pulse) |=> !eoc [*8] ##1 !eoc [*3])
    else $error("end of conversion not low through conversion");

  eoc_rise_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == ASF_DONE && buf_in_ready) |=> (eoc && state == ASF_IDLE))
    else $error("end of conversion did not rise");

  half_zero_test_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == ASF_DONE) |-> ((conv_addr != CODE_HALF || {result, 6'h00} == 16'h8000)
      && (conv_addr != CODE_ZERO || {result, 6'h00} == 16'h0000)))
    else $error("half or zero test word wrong");

  full_test_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == ASF_DONE && conv_addr == CODE_FULL) |-> ({result, 6'h00} == 16'hffc0))
    else $error("full scale test word wrong");

  input_select_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == ASF_IDLE && start_pulse && link_addr == CODE_IN2)
      |-> ##11 (state == ASF_DONE && result == $past(analog_input_two, 11)))
    else $error("wrong input converted");
endmodule // asf_frame
`default_nettype wire

// ---- include/asf_pkg.sv ----
package asf_pkg;
  localparam int RES_W = 10;
  localparam int PAD_W = 6;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 4;
  localparam int BUF_DEPTH = 2;
  // channel select codes carried in the top nibble of a frame
  localparam logic [3:0] CODE_IN0 = 4'h0;
  localparam logic [3:0] CODE_IN1 = 4'h1;
  localparam logic [3:0] CODE_IN2 = 4'h2;
  localparam logic [3:0] CODE_IN3 = 4'h3;
  localparam logic [3:0] CODE_IN4 = 4'h4;
  localparam logic [3:0] CODE_HALF = 4'hb;
  localparam logic [3:0] CODE_ZERO = 4'hc;
  localparam logic [3:0] CODE_FULL = 4'hd;
  // internal test source levels
  localparam logic [9:0] LVL_HALF = 10'h200;
  localparam logic [9:0] LVL_ZERO = 10'h000;
  localparam logic [9:0] LVL_FULL = 10'h3ff;
  // falling-edge count before the tenth, the sixteenth and the eleventh fall of a frame
  localparam logic [3:0] FALL_START = 4'h9;
  localparam logic [3:0] FALL_LAST = 4'hf;
  localparam logic [3:0] FALL_PAD = 4'ha;
  localparam logic [3:0] STEP_TOP = 4'h9;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  typedef enum logic [1:0] {
    ASF_IDLE = 2'b00,
    ASF_CONV = 2'b01,
    ASF_DONE = 2'b10
  } asf_state_type;
endpackage

// ---- sim/asf_host.sv ----
`timescale 1ns/1ns
`default_nettype none
module asf_host (
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout,
  output logic [15:0] rx_word,
  output logic rx_stb
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
    rx_word = 16'h0000;
    rx_stb = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // full duplex frame
  task automatic xfer(input logic [15:0] tx, input bit split, input bit keep_cs);
    cs_n = 1'b0;
    #80;
    for (int i = 15; i >= 0; i--) begin
      din = tx[i];
      #80 sclk = 1'b1;
      rx_word[i] = dout;
      #80 sclk = 1'b0;
      if (split && i == 8) begin
        din = ~din;
        #(400 + $urandom_range(0, 300));
      end
    end
    // released line must not keep its last level
    din = ~din;
    #80;
    if (!keep_cs) cs_n = 1'b1;
    rx_stb = 1'b1;
    #1 rx_stb = 1'b0;
  endtask
endmodule // asf_host
`default_nettype wire

// ---- sim/test_asf_frame.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_asf_frame
  import asf_pkg::*;
();
  logic core_clk;
  logic rst_n;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout;
  logic eoc;
  logic rx_stb;
  logic [15:0] rx_word;
  logic [9:0] ain [5];
  logic [15:0] exp_q [$];
  logic [15:0] pend;
  logic [3:0] codes [8];
  int fails;
  int tests_run;
  int eoc_falls;
  bit hung;

  always #2 core_clk = ~core_clk;

  asf_frame uut (
    .core_clk(core_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout(dout), .eoc(eoc), .analog_input_zero(ain[0]), .analog_input_one(ain[1]),
    .analog_input_two(ain[2]), .analog_input_three(ain[3]), .analog_input_four(ain[4])
  );
  asf_host host (
    .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .rx_word(rx_word), .rx_stb(rx_stb)
  );
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  function automatic logic [15:0] word_for(input logic [3:0] code);
    case (code)
      CODE_HALF: return 16'h8000;
      CODE_ZERO: return 16'h0000;
      CODE_FULL: return 16'hffc0;
      default: return {ain[code[2:0]], 6'h00};
    endcase
  endfunction

  always @(negedge eoc) begin
    if (rst_n === 1'b1) eoc_falls++;
  end

  // oldest note is matched against each returned word
  always @(posedge rx_stb) begin
    logic [15:0] exp;
    if (exp_q.size() == 0) begin
      fails++;
      $display("ERROR frame word expected none seen %h", rx_word);
    end else begin
      exp = exp_q.pop_front();
      check("frame word", exp, rx_word);
      check("shifted value", {6'h00, exp[15:6]}, rx_word >> 6);
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic frame(input logic [3:0] code, input bit split, input bit keep_cs);
    int n;
    int f0;
    f0 = eoc_falls;
    exp_q.push_back(pend);
    pend = word_for(code);
    #($urandom_range(1, 3));
    host.xfer({code, 12'($urandom)}, split, keep_cs);
    n = 0;
    while (eoc !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    if (eoc !== 1'b1) begin
      fails++;
      $display("ERROR eoc expected 1 seen %b", eoc);
      // a hung link skips the rest and goes to the closing report
      hung = 1'b1;
      return;
    end
    check("eoc falls", 16'(f0 + 1), 16'(eoc_falls));
    // levels change only once the conversion has sampled them
    @(posedge core_clk);
    #1;
    foreach (ain[i]) ain[i] = 10'($urandom);
  endtask

  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    fails = 0;
    tests_run = 0;
    eoc_falls = 0;
    hung = 1'b0;
    pend = 16'h0000;
    void'($urandom(86721));
    codes = '{CODE_IN0, CODE_IN1, CODE_IN2, CODE_IN3, CODE_IN4, CODE_HALF, CODE_ZERO,
      CODE_FULL};
    foreach (ain[i]) ain[i] = 10'($urandom);
    ain[0] = 10'h3ff;
    ain[1] = 10'h000;
    repeat (20) @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge core_clk);
    check("eoc after reset", 16'h0001, {15'h0000, eoc});
    for (int p = 0; p < 3; p++) begin
      for (int k = 0; k < 8 && !hung; k++) begin
        frame(p == 2 ? codes[$urandom_range(0, 7)] : codes[k], p == 1, p != 2);
      end
    end
    if (!hung) frame(CODE_IN0, 1'b0, 1'b0);
    repeat (10) @(posedge core_clk);
    check("pending words", 16'h0000, 16'(exp_q.size()));
    print_verdict();
  end
endmodule // test_asf_frame
`default_nettype wire
